// >>> rtl/rgam_consts.svh
// Constants for the region attribute match block.
// Assumes inclusion by bare name from the package and the top module.
// Function
// - Two independent region attribute registers provided
// - Base match bits 31-24 compared with address
// - Set mask bits exclude matching base bits
// - Enable bit 15 gates all region fields
// - Privilege field selects user, supervisor, or all
// - Skip region check for on-chip SRAM/ROM
// - Unclaimed references take cache control defaults
// - Supervisor-only access via selectors 004/005/002
// - Debug mode may read and write regions
// - Line fetch field sizes cache bus requests
`ifndef RGAM_CONSTS_SVH
`define RGAM_CONSTS_SVH

// ----------------------------------------------------------------
// Control register selectors
// ----------------------------------------------------------------
`define RGAM_SEL_CACHE_CONTROL 12'h002
`define RGAM_SEL_REGION_0 12'h004
`define RGAM_SEL_REGION_1 12'h005

// ----------------------------------------------------------------
// Region register field positions
// ----------------------------------------------------------------
`define RGAM_BASE_HI 31
`define RGAM_BASE_LO 24
`define RGAM_MASK_HI 23
`define RGAM_MASK_LO 16
`define RGAM_EN_BIT 15
`define RGAM_PRIV_HI 14
`define RGAM_PRIV_LO 13
`define RGAM_RSVD_HI 12
`define RGAM_RSVD_LO 7

// ----------------------------------------------------------------
// Cache control field positions and reset values
// ----------------------------------------------------------------
`define RGAM_LNF_HI 1
`define RGAM_LNF_LO 0
`define RGAM_REGION_RESET 32'h0000_0000
`define RGAM_CACHE_RESET 32'h0000_0000

`endif

// >>> rtl/rgam_pkg.sv
// Types for the region attribute match block.
// Assumes the constants header sits beside it on the include path.
`include "rgam_consts.svh"

package rgam_pkg;

    // ------------------------------------------------------------
    // Memory reference from the core
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;        // Reference present this cycle
        logic [31:0] addr;  // Byte address
        logic supervisor;   // Core privilege mode
        logic onchip;       // Targets on-chip SRAM or ROM
    } rgam_ref_t;

    // ------------------------------------------------------------
    // Resolved attributes for the reference
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RGAM_SRC_ONCHIP,
        RGAM_SRC_DEFAULT,
        RGAM_SRC_REGION0,
        RGAM_SRC_REGION1
    } rgam_src_t;

    typedef struct packed {
        logic valid;          // Result valid
        rgam_src_t src;       // Which register supplied attributes
        logic [31:0] attr;    // Attribute word from that register
        logic line_request;   // 1: line fill, 0: single longword
    } rgam_result_t;

    // ------------------------------------------------------------
    // Control register move access
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;          // Read strobe
        logic write;         // Write strobe
        logic [11:0] sel;    // Control selector
        logic [31:0] wdata;  // Write data
        logic supervisor;    // Issued at supervisor level
        logic debug;         // Issued from background debug mode
    } rgam_ctl_t;

    // ------------------------------------------------------------
    // Whole module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] cache_control;
        logic [31:0] region_0;
        logic [31:0] region_1;
        logic [31:0] rdata;
        logic ack;
        logic err;
        rgam_result_t res;
    } rgam_state_t;

endpackage

// >>> rtl/rgam_region_attribute_match.sv
// Region attribute match: holds the two region registers and cache
// control, resolves attributes per reference, and sizes line fetches.
// Assumes the core and bus controller share this clock; inputs are
// synchronous to it.
`timescale 1ns/10ps
`include "rgam_consts.svh"

module rgam_region_attribute_match (
    input wire logic clock,
    input wire logic rstn,
    input wire rgam_pkg::rgam_ref_t ref_in,
    input wire rgam_pkg::rgam_ctl_t ctl_in,
    output rgam_pkg::rgam_result_t result,
    output logic [31:0] ctl_rdata,
    output logic ctl_ack,
    output logic ctl_err,
    output logic [31:0] cache_control,
    output logic [31:0] region_attributes_0,
    output logic [31:0] region_attributes_1
);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta_reg; // First stage, read only by second
    logic rst_sync_reg; // Released reset used by all logic

    // Async assert, clocked release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Region hit test, shared by both registers
    function automatic logic region_hit(
        input logic [31:0] region,
        input logic [31:0] addr,
        input logic sup
    );
        logic [7:0] diff;
        logic priv_ok;
        begin
            // Masked bits drop out of the compare
            diff = (region[`RGAM_BASE_HI:`RGAM_BASE_LO]
                    ^ addr[31:24])
                   & ~region[`RGAM_MASK_HI:`RGAM_MASK_LO];
            // 1x matches all, else mode must agree
            priv_ok = region[`RGAM_PRIV_HI]
                      || (region[`RGAM_PRIV_LO] == sup);
            // Disabled region never claims anything
            region_hit = region[`RGAM_EN_BIT]
                         && priv_ok && (diff == 8'h00);
        end
    endfunction

    // Line versus longword from fetch code and offset
    function automatic logic line_size(
        input logic [1:0] code,
        input logic [1:0] offs
    );
        begin
            unique case (code)
                2'h0: line_size = (offs != 2'h3);
                2'h1: line_size = !offs[1];
                default: line_size = 1'b1;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rgam_pkg::rgam_state_t state_reg; // All registered state
    rgam_pkg::rgam_state_t state_next; // Next value

    logic hit0; // Region 0 claims the reference
    logic hit1; // Region 1 claims the reference
    logic ctl_allowed; // Supervisor or debug access
    logic sel_known; // Selector decodes to a register here

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // Two independent copies of the compare
        hit0 = region_hit(state_reg.region_0, ref_in.addr,
                          ref_in.supervisor);
        hit1 = region_hit(state_reg.region_1, ref_in.addr,
                          ref_in.supervisor);

        // Reference resolution, one cycle latency
        state_next.res.valid = ref_in.valid;
        state_next.res.line_request = line_size(
            state_reg.cache_control[`RGAM_LNF_HI:`RGAM_LNF_LO],
            ref_in.addr[3:2]);
        if (ref_in.onchip) begin
            // On-chip targets bypass region lookup
            state_next.res.src = rgam_pkg::RGAM_SRC_ONCHIP;
            state_next.res.attr = state_reg.cache_control;
        end else if (hit0) begin
            // Region 0 has priority on overlap
            state_next.res.src = rgam_pkg::RGAM_SRC_REGION0;
            state_next.res.attr = state_reg.region_0;
        end else if (hit1) begin
            state_next.res.src = rgam_pkg::RGAM_SRC_REGION1;
            state_next.res.attr = state_reg.region_1;
        end else begin
            // Nobody claims it: cache control defaults
            state_next.res.src = rgam_pkg::RGAM_SRC_DEFAULT;
            state_next.res.attr = state_reg.cache_control;
        end

        // Control register move access
        ctl_allowed = ctl_in.supervisor || ctl_in.debug;
        sel_known = (ctl_in.sel == `RGAM_SEL_CACHE_CONTROL)
                    || (ctl_in.sel == `RGAM_SEL_REGION_0)
                    || (ctl_in.sel == `RGAM_SEL_REGION_1);
        state_next.ack = 1'b0;
        state_next.err = 1'b0;
        state_next.rdata = 32'h0000_0000;
        if (ctl_in.read || ctl_in.write) begin
            if (ctl_allowed && sel_known) begin
                state_next.ack = 1'b1;
            end else begin
                // User level or unknown selector: no effect
                state_next.err = 1'b1;
            end
        end
        if (ctl_in.write && ctl_allowed) begin
            // Reserved bits stored as written; software keeps them 0
            if (ctl_in.sel == `RGAM_SEL_CACHE_CONTROL) begin
                state_next.cache_control = ctl_in.wdata;
            end
            if (ctl_in.sel == `RGAM_SEL_REGION_0) begin
                state_next.region_0 = ctl_in.wdata;
            end
            if (ctl_in.sel == `RGAM_SEL_REGION_1) begin
                state_next.region_1 = ctl_in.wdata;
            end
        end else if (ctl_in.read && ctl_allowed) begin
            // Read returns current contents; a write strobe in the same cycle wins and rdata stays 0
            if (ctl_in.sel == `RGAM_SEL_CACHE_CONTROL) begin
                state_next.rdata = state_reg.cache_control;
            end
            if (ctl_in.sel == `RGAM_SEL_REGION_0) begin
                state_next.rdata = state_reg.region_0;
            end
            if (ctl_in.sel == `RGAM_SEL_REGION_1) begin
                state_next.rdata = state_reg.region_1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg.cache_control <= `RGAM_CACHE_RESET;
            state_reg.region_0 <= `RGAM_REGION_RESET;
            state_reg.region_1 <= `RGAM_REGION_RESET;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.ack <= 1'b0;
            state_reg.err <= 1'b0;
            state_reg.res <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign result = state_reg.res;
    assign ctl_rdata = state_reg.rdata;
    assign ctl_ack = state_reg.ack;
    assign ctl_err = state_reg.err;
    assign cache_control = state_reg.cache_control;
    assign region_attributes_0 = state_reg.region_0;
    assign region_attributes_1 = state_reg.region_1;

endmodule

// >>> bench/rgam_chk.sv
// Checker for the region attribute match block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module rgam_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire rgam_pkg::rgam_ref_t ref_in,
    input wire rgam_pkg::rgam_ctl_t ctl_in,
    input wire rgam_pkg::rgam_result_t result,
    input wire logic [31:0] ctl_rdata,
    input wire logic ctl_ack,
    input wire logic ctl_err,
    input wire logic [31:0] cache_control,
    input wire logic [31:0] region_attributes_0,
    input wire logic [31:0] region_attributes_1
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Claim test: enable, masked base, privilege
    function automatic logic hit(logic [31:0] r, logic [31:0] a, logic s);
        return r[15] && (((r[31:24] ^ a[31:24]) & ~r[23:16]) == 8'h00)
            && (r[14] || r[13] == s);
    endfunction
    logic go, h0, h1, ln, rq; // Qualified reference and region claims
    assign go = ref_in.valid && !ref_in.onchip;
    assign h0 = hit(region_attributes_0, ref_in.addr, ref_in.supervisor);
    assign h1 = hit(region_attributes_1, ref_in.addr, ref_in.supervisor);
    assign rq = ctl_in.read || ctl_in.write;
    // Line fill unless the offset calls for a single longword
    assign ln = cache_control[1] || (cache_control[0] ?
        ref_in.addr[3:2] < 2'h2 : ref_in.addr[3:2] != 2'h3);
    a_ctl_answer: assert property (rq |=> ctl_ack ^ ctl_err)
        else $error("control access not answered once");
    a_user_refused: assert property (
        rq && !ctl_in.supervisor && !ctl_in.debug |=>
        ctl_err && ctl_rdata == 32'h0)
        else $error("user access not refused");
    a_debug_write: assert property (
        ctl_in.write && ctl_in.debug && ctl_in.sel == 12'h005 |=>
        ctl_ack && region_attributes_1 == $past(ctl_in.wdata))
        else $error("debug write to region 1 lost");
    a_sup_write: assert property (
        ctl_in.write && ctl_in.supervisor && ctl_in.sel == 12'h004 |=>
        region_attributes_0 == $past(ctl_in.wdata))
        else $error("supervisor write to region 0 lost");
    a_onchip_skip: assert property (
        ref_in.valid && ref_in.onchip |=>
        result.src == rgam_pkg::RGAM_SRC_ONCHIP)
        else $error("on-chip reference went through regions");
    a_region0_wins: assert property (
        go && h0 |=>
        result.src == rgam_pkg::RGAM_SRC_REGION0 &&
        result.attr == $past(region_attributes_0))
        else $error("region 0 claim not applied");
    a_region1_hit: assert property (
        go && !h0 && h1 |=>
        result.src == rgam_pkg::RGAM_SRC_REGION1 &&
        result.attr == $past(region_attributes_1))
        else $error("region 1 claim not applied");
    a_default_attr: assert property (
        go && !h0 && !h1 |=>
        result.src == rgam_pkg::RGAM_SRC_DEFAULT &&
        result.attr == $past(cache_control))
        else $error("default attributes not applied");
    a_line_size: assert property (
        ref_in.valid |=> result.line_request == $past(ln))
        else $error("request size wrong");
endmodule
bind rgam_region_attribute_match rgam_chk u_chk (.clock, .rstn, .ref_in,
    .ctl_in, .result, .ctl_rdata, .ctl_ack, .ctl_err, .cache_control,
    .region_attributes_0, .region_attributes_1);

// >>> bench/rgam_bus_model.sv
// Bus controller model: tallies request sizes from the cache side.
// Assumes results are sampled on the rising core clock edge.
`timescale 1ns/10ps
module rgam_bus_model (
    input wire logic clock,
    input wire logic rstn,
    input wire rgam_pkg::rgam_result_t result,
    output int n_line,
    output int n_long
);
    // Accepts every request at once; sizes kept apart for the bench
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            n_line <= 0;
            n_long <= 0;
        end else if (result.valid && result.line_request) begin
            n_line <= n_line + 1;
        end else if (result.valid) begin
            n_long <= n_long + 1;
        end
    end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the region attribute match block.
// Assumes the package is compiled first; single 200 MHz clock.
`timescale 1ns/10ps
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    rgam_pkg::rgam_ref_t ref_in = '0;
    rgam_pkg::rgam_ctl_t ctl_in = '0;
    rgam_pkg::rgam_result_t result;
    logic [31:0] ctl_rdata, w, v, a;
    logic ctl_ack, ctl_err;
    logic [31:0] cc_q, r0_q, r1_q; // Register contents seen at the ports
    logic [31:0] m_cc = '0, m_r0 = '0, m_r1 = '0; // Model registers
    logic [31:0] seed = 32'h0001_0445;
    logic [11:0] sels [3] = '{12'h002, 12'h004, 12'h005};
    int n_fail = 0, n_compared = 0, cycles = 0, m_line = 0, m_long = 0;
    int n_line, n_long;
    always #2.5 clock = ~clock;
    rgam_region_attribute_match dut (.clock, .rstn, .ref_in, .ctl_in,
        .result, .ctl_rdata, .ctl_ack, .ctl_err, .cache_control(cc_q),
        .region_attributes_0(r0_q), .region_attributes_1(r1_q));
    rgam_bus_model bus (.clock, .rstn, .result, .n_line, .n_long);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic mh(logic [31:0] r, logic [31:0] x, logic s);
        return r[15] && (((r[31:24] ^ x[31:24]) & ~r[23:16]) == 8'h00)
            && (r[14] || r[13] == s);
    endfunction
    task automatic fail(string m);
        n_fail++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic chk_ctl(logic k, logic e, logic [31:0] d);
        n_compared++;
        if ({ctl_ack, ctl_err, ctl_rdata} !== {k, e, d}) fail("control");
    endtask
    task automatic chk_ref(logic [1:0] s, logic [31:0] t, logic l);
        n_compared++;
        if ({result.valid, result.src, result.attr, result.line_request}
            !== {1'b1, s, t, l}) fail("reference");
    endtask
    // Register contents against the model copies
    task automatic chk_reg();
        n_compared++;
        if ({cc_q, r0_q, r1_q} !== {m_cc, m_r0, m_r1}) fail("registers");
    endtask
    // One strobe cycle, answer checked one edge later
    task automatic ctl(logic wr, logic [11:0] sl, logic [31:0] d,
        logic sp, logic db);
        logic ok;
        logic [31:0] q;
        ok = (sp || db) && (sl == 12'h002 || sl == 12'h004 || sl == 12'h005);
        q = sl == 12'h002 ? m_cc : sl == 12'h004 ? m_r0 : m_r1;
        @(posedge clock);
        ctl_in <= '{!wr, wr, sl, d, sp, db};
        @(posedge clock);
        ctl_in <= '0;
        #1 chk_ctl(ok, !ok, ok && !wr ? q : 32'h0);
        if (ok && wr && sl == 12'h002) m_cc = d;
        if (ok && wr && sl == 12'h004) m_r0 = d;
        if (ok && wr && sl == 12'h005) m_r1 = d;
        chk_reg();
    endtask
    task automatic rf(logic [31:0] x, logic s, logic o);
        rgam_pkg::rgam_src_t sr;
        logic l;
        logic [31:0] t;
        l = m_cc[1] || (m_cc[0] ? x[3:2] < 2'h2 : x[3:2] != 2'h3);
        sr = o ? rgam_pkg::RGAM_SRC_ONCHIP : mh(m_r0, x, s) ?
            rgam_pkg::RGAM_SRC_REGION0 : mh(m_r1, x, s) ?
            rgam_pkg::RGAM_SRC_REGION1 : rgam_pkg::RGAM_SRC_DEFAULT;
        // Attribute word of whichever register claims it
        t = sr == rgam_pkg::RGAM_SRC_REGION0 ? m_r0 :
            sr == rgam_pkg::RGAM_SRC_REGION1 ? m_r1 : m_cc;
        m_line += l;
        m_long += !l;
        @(posedge clock);
        ref_in <= '{1'b1, x, s, o};
        @(posedge clock);
        ref_in <= '0;
        #1 chk_ref(sr, t, l);
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk_reg();
        foreach (sels[i]) ctl(1'b0, sels[i], 32'h0, 1'b1, 1'b0);
        ctl(1'b1, 12'h004, 32'hFFFF_FFFF, 1'b0, 1'b0);
        ctl(1'b0, 12'h801, 32'h0, 1'b1, 1'b0);
        ctl(1'b1, 12'h005, 32'h12FF_C000, 1'b0, 1'b1);
        ctl(1'b0, 12'h005, 32'h0, 1'b0, 1'b1);
        rf(32'h0034_000C, 1'b0, 1'b0);
        // Random settings; addresses often aimed at a region base
        repeat (150) begin
            w = rnd() & 32'hFFFF_E07F;
            v = rnd();
            if (v[2]) w[31:24] = m_r0[31:24];
            ctl(1'b1, sels[v[1:0] % 3], w, 1'b1, 1'b0);
            // Read back from supervisor or debug level
            ctl(1'b0, sels[v[1:0] % 3], 32'h0, v[3], !v[3]);
            repeat (4) begin
                a = rnd();
                if (a[4]) a[31:24] = a[5] ? m_r1[31:24] : m_r0[31:24];
                rf(a, a[6], a[7] & a[8]);
            end
        end
        // Bus model counts the last result one edge later
        @(posedge clock);
        #1 n_compared++;
        if (n_line !== m_line) fail("line count");
        n_compared++;
        if (n_long !== m_long) fail("longword count");
        print_verdict();
    end
endmodule
